/* hdl/exec_pkg.sv */
package exec_pkg;

  // ----------------------------------------------------------------
  // Status word layout
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W = 16;
  localparam int unsigned CARRY_POS = 0;
  localparam int unsigned ZERO_POS = 1;
  localparam int unsigned NEG_POS = 2;
  localparam int unsigned GIE_POS = 3;
  localparam int unsigned HALT_POS = 4;
  localparam int unsigned OSC_POS = 5;
  localparam int unsigned OVF_POS = 8;
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] STACK_STEP = 16'h0002;

  // ----------------------------------------------------------------
  // Operations and sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    op_subroutine_exit = 2'b00,
    op_interrupt_exit = 2'b01,
    op_arith_shift_left = 2'b10,
    op_none = 2'b11
  } op_type;

  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_pop_pc = 3'b001,
    st_pop_flags = 3'b010,
    st_done = 3'b011
  } state_type;

  typedef struct packed {
    op_type op;
    logic byte_mode;
    logic [15:0] operand;
  } request_type;

  typedef struct packed {
    logic [15:0] result;
    logic neg;
    logic zero;
    logic carry;
    logic ovf;
  } shift_result_type;

endpackage : exec_pkg

/* hdl/shift_left_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module shift_left_unit
  import exec_pkg::*;
(
  input wire logic [15:0] operand,
  input wire logic byte_mode,
  output var shift_result_type res
);

  logic [16:0] sum_w;
  logic [8:0] sum_b;

  always_comb begin
    // Shift is done as operand plus itself
    sum_w = {1'b0, operand} + {1'b0, operand};
    sum_b = {1'b0, operand[7:0]} + {1'b0, operand[7:0]};
    if (byte_mode) begin
      // High byte of the result is cleared for the byte form
      res.result = {8'h00, sum_b[7:0]};
      res.carry = sum_b[8];
      res.neg = sum_b[7];
      res.zero = (sum_b[7:0] == 8'h00);
      res.ovf = (operand[7:0] >= 8'h40) && (operand[7:0] < 8'hc0);
    end else begin
      res.result = sum_w[15:0];
      res.carry = sum_w[16];
      res.neg = sum_w[15];
      res.zero = (sum_w[15:0] == 16'h0000);
      res.ovf = (operand >= 16'h4000) && (operand < 16'hc000);
    end
  end

endmodule : shift_left_unit
`default_nettype wire

/* hdl/return_and_shift_left_exec.sv */
// How it works
// - Subroutine exit pops program counter, bumps stack
// - Subroutine exit keeps all status flags
// - Interrupt exit pops status word first
// - Then pops program counter, stack plus two
// - Interrupt exit flags come from popped word
// - Mode bits restored from popped word too
// - Shift left, old top bit into carry
// - Shift equals adding operand to itself
// - Word overflow when 4000h <= operand < C000h
// - Byte overflow when 40h <= operand < C0h
// - Negative from result sign, zero if zero
// - Shift keeps mode bits unchanged
`timescale 1ns/1ps
`default_nettype none
module return_and_shift_left_exec
  import exec_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic req_valid,
  output logic req_ready,
  input wire request_type req,
  output logic mem_rd,
  output logic [15:0] mem_addr,
  input wire logic [15:0] stack_top_word,
  output logic done,
  output logic [15:0] shift_result,
  output logic [15:0] prog_counter,
  output logic [15:0] stack_ptr,
  output logic [15:0] flags_word_reg,
  output logic oscillator_disable_bit,
  output logic core_halt_bit,
  output logic global_irq_enable
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  state_type state_q, state_d;
  logic [15:0] pc_q, pc_d;
  logic [15:0] sp_q, sp_d;
  logic [15:0] sr_q, sr_d;
  logic [15:0] res_q, res_d;
  shift_result_type sh;
  logic take_req;
  logic take_shift;
  logic take_sub;
  logic take_irq;
  logic pop_flags;
  logic pop_pc;

  shift_left_unit i_shift_left_unit (
    .operand(req.operand),
    .byte_mode(req.byte_mode),
    .res(sh)
  );

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  // A request counts only in idle, so a stray valid mid-pop is dropped
  always_comb begin
    take_req = req_valid && (state_q == st_idle);
    take_shift = take_req && (req.op == op_arith_shift_left);
    take_sub = take_req && (req.op == op_subroutine_exit);
    take_irq = take_req && (req.op == op_interrupt_exit);
    pop_flags = (state_q == st_pop_flags);
    pop_pc = (state_q == st_pop_pc);
    mem_rd = pop_flags || pop_pc;
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Memory returns the stack word in the same cycle the address stands,
  // so each pop takes one cycle; trades speed for no read pipeline.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      st_idle: begin
        if (take_shift) begin
          state_d = st_done;
        end else if (take_irq) begin
          state_d = st_pop_flags;
        end else if (take_sub) begin
          state_d = st_pop_pc;
        end
      end
      st_pop_flags: state_d = st_pop_pc;
      st_pop_pc: state_d = st_done;
      st_done: state_d = st_idle;
      default: state_d = st_idle;
    endcase
  end

  // Clock enable low freezes every register group below
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= st_idle;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Stack pointer
  // ----------------------------------------------------------------
  // Both pops step by two whatever the operand width
  always_comb begin
    sp_d = sp_q;
    if (pop_flags || pop_pc) begin
      sp_d = sp_q + STACK_STEP;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sp_q <= SP_RESET;
    end else if (clk_en) begin
      sp_q <= sp_d;
    end
  end

  // ----------------------------------------------------------------
  // Program counter
  // ----------------------------------------------------------------
  always_comb begin
    pc_d = pc_q;
    if (pop_pc) begin
      pc_d = stack_top_word;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pc_q <= PC_RESET;
    end else if (clk_en) begin
      pc_q <= pc_d;
    end
  end

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  // A pop and a shift never share a cycle, so neither masks the other
  always_comb begin
    sr_d = sr_q;
    if (pop_flags) begin
      // Whole word replaces flags and mode bits
      sr_d = stack_top_word;
    end else if (take_shift) begin
      // Only arithmetic flags change; mode bits kept
      sr_d[CARRY_POS] = sh.carry;
      sr_d[ZERO_POS] = sh.zero;
      sr_d[NEG_POS] = sh.neg;
      sr_d[OVF_POS] = sh.ovf;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sr_q <= FLAGS_RESET;
    end else if (clk_en) begin
      sr_q <= sr_d;
    end
  end

  // ----------------------------------------------------------------
  // Shift result
  // ----------------------------------------------------------------
  always_comb begin
    res_d = res_q;
    if (take_shift) begin
      res_d = sh.result;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      res_q <= 16'h0000;
    end else if (clk_en) begin
      res_q <= res_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign req_ready = (state_q == st_idle) && clk_en;
  assign mem_addr = sp_q;
  assign done = (state_q == st_done);
  assign shift_result = res_q;
  assign prog_counter = pc_q;
  assign stack_ptr = sp_q;
  assign flags_word_reg = sr_q;
  assign oscillator_disable_bit = sr_q[OSC_POS];
  assign core_halt_bit = sr_q[HALT_POS];
  assign global_irq_enable = sr_q[GIE_POS];

endmodule : return_and_shift_left_exec
`default_nettype wire

/* bench/exec_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module exec_properties
  import exec_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire request_type req,
  input wire logic mem_rd,
  input wire logic [15:0] stack_top_word,
  input wire logic done,
  input wire logic [15:0] shift_result,
  input wire logic [15:0] prog_counter,
  input wire logic [15:0] stack_ptr,
  input wire logic [15:0] flags_word_reg
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // Request copy, one cycle late
  // ----------------------------------------
  logic [15:0] o_q;
  logic b_q;
  always_ff @(posedge clk_sys) begin
    o_q <= req.operand;
    b_q <= req.byte_mode;
  end
  wire logic go = req_valid && req_ready;
  wire logic sh = go && req.op == op_arith_shift_left;
  wire logic se = go && req.op == op_subroutine_exit;
  wire logic ie = go && req.op == op_interrupt_exit;
  wire logic [15:0] f = flags_word_reg;
  wire logic [15:0] r_e = b_q ? {8'h00, o_q[6:0], 1'b0} : {o_q[14:0], 1'b0};
  wire logic v_e = b_q ? (o_q[7:0] >= 8'h40 && o_q[7:0] < 8'hc0)
                       : (o_q >= 16'h4000 && o_q < 16'hc000);
  property p_sh_val;
    sh |=> done && shift_result == r_e && f[CARRY_POS] == (b_q ? o_q[7] : o_q[15]);
  endproperty
  a_sh_val: assert property (p_sh_val) else $error("shift value");
  property p_sh_v;
    sh |=> f[OVF_POS] == v_e;
  endproperty
  a_sh_v: assert property (p_sh_v) else $error("shift overflow");
  property p_sh_nz;
    sh |=> f[ZERO_POS] == (r_e == 16'h0000) && f[NEG_POS] == r_e[b_q ? 7 : 15];
  endproperty
  a_sh_nz: assert property (p_sh_nz) else $error("shift sign or zero");
  property p_sh_mode;
    sh |=> $stable(f[OSC_POS:GIE_POS]);
  endproperty
  a_sh_mode: assert property (p_sh_mode) else $error("shift mode bits");
  property p_se_pc;
    se |=> mem_rd ##1 done && prog_counter == $past(stack_top_word)
      && stack_ptr == $past(stack_ptr) + 16'h0002;
  endproperty
  a_se_pc: assert property (p_se_pc) else $error("return pop");
  property p_se_flag;
    se |=> $stable(f) [*2];
  endproperty
  a_se_flag: assert property (p_se_flag) else $error("return flags");
  property p_ie_sr;
    ie |=> mem_rd ##1 f == $past(stack_top_word) && stack_ptr == $past(stack_ptr) + 16'h0002;
  endproperty
  a_ie_sr: assert property (p_ie_sr) else $error("status pop");
  property p_ie_pc;
    ie |=> ##1 mem_rd ##1 done && prog_counter == $past(stack_top_word)
      && stack_ptr == $past(stack_ptr) + 16'h0002;
  endproperty
  a_ie_pc: assert property (p_ie_pc) else $error("counter pop");
  cover property (sh && req.byte_mode);
  cover property (se);
  cover property (ie);
endmodule : exec_properties
bind return_and_shift_left_exec exec_properties i_props (.*);
`default_nettype wire

/* bench/return_and_shift_left_exec_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module return_and_shift_left_exec_bench
  import exec_pkg::*;
;
  logic clk_sys = 0;
  logic sys_rst = 1;
  logic req_valid = 0;
  logic clk_en = 1;
  logic oscillator_disable_bit, core_halt_bit, global_irq_enable;
  request_type req = '{op_none, 1'b0, 16'h0000};
  logic req_ready, mem_rd, done;
  logic [15:0] mem_addr, shift_result, prog_counter, stack_ptr, flags_word_reg;
  logic [15:0] ef = 16'h00ff;
  int fail_count = 0;
  int n_tests = 0;
  // Stack memory answers in the same cycle
  wire logic [15:0] stack_top_word = {mem_addr[7:0], ~mem_addr[7:0]};
  always #2.5 clk_sys = ~clk_sys;
  return_and_shift_left_exec i_return_and_shift_left_exec (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .clk_en(clk_en), .req_valid(req_valid), .req_ready(req_ready), .req(req), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .stack_top_word(stack_top_word), .done(done),
    .shift_result(shift_result), .prog_counter(prog_counter), .stack_ptr(stack_ptr),
    .flags_word_reg(flags_word_reg), .oscillator_disable_bit(oscillator_disable_bit),
    .core_halt_bit(core_halt_bit), .global_irq_enable(global_irq_enable));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic issue(input op_type op, input logic bm, input logic [15:0] d, input int n);
    @(posedge clk_sys);
    req <= '{op, bm, d};
    req_valid <= 1'b1;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    repeat (n - 1) @(posedge clk_sys);
    #1;
    chk({15'h0000, done}, 16'h0001);
  endtask : issue
  task automatic t_returns();
    issue(op_interrupt_exit, 1'b0, 16'h0000, 3);
    chk(flags_word_reg, 16'h00ff);
    chk(prog_counter, 16'h02fd);
    chk(stack_ptr, 16'h0004);
    chk({13'h0000, oscillator_disable_bit, core_halt_bit, global_irq_enable}, 16'h0007);
    issue(op_subroutine_exit, 1'b0, 16'h0000, 2);
    chk(prog_counter, 16'h04fb);
    chk(stack_ptr, 16'h0006);
    chk(flags_word_reg, 16'h00ff);
    $display("returns done");
  endtask : t_returns
  task automatic t_shifts();
    logic [15:0] d[10] = '{16'h4000, 16'h3fff, 16'hbfff, 16'hc000, 16'h8000,
      16'hff40, 16'h003f, 16'h00bf, 16'h00c0, 16'h0080};
    logic [15:0] e;
    logic bm;
    for (int i = 0; i < 10; i++) begin
      bm = i >= 5;
      e = bm ? {8'h00, d[i][6:0], 1'b0} : {d[i][14:0], 1'b0};
      ef[CARRY_POS] = bm ? d[i][7] : d[i][15];
      ef[ZERO_POS] = e == 16'h0000;
      ef[NEG_POS] = bm ? e[7] : e[15];
      ef[OVF_POS] = bm ? (d[i][7:0] >= 8'h40 && d[i][7:0] < 8'hc0)
                       : (d[i] >= 16'h4000 && d[i] < 16'hc000);
      issue(op_arith_shift_left, bm, d[i], 1);
      chk(shift_result, e);
      chk(flags_word_reg, ef);
    end
    chk({13'h0000, oscillator_disable_bit, core_halt_bit, global_irq_enable}, 16'h0007);
    $display("shifts done");
  endtask : t_shifts
  task automatic t_freeze();
    logic [15:0] r0;
    r0 = shift_result;
    @(posedge clk_sys);
    clk_en <= 1'b0;
    req <= '{op_arith_shift_left, 1'b0, 16'h0001};
    req_valid <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    chk({15'h0000, req_ready}, 16'h0000);
    chk({15'h0000, done}, 16'h0000);
    chk(shift_result, r0);
    @(posedge clk_sys);
    req_valid <= 1'b0;
    clk_en <= 1'b1;
    $display("freeze done");
  endtask : t_freeze
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    #20000;
    fail_count++;
    wrap_up();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_returns();
    t_shifts();
    t_freeze();
    wrap_up();
  end
endmodule : return_and_shift_left_exec_bench
`default_nettype wire
